//--- design/bioz_cfg_params.svh
// Offsets, field positions, reset values and special codes of the channel configuration block
`ifndef BIOZ_CFG_PARAMS_SVH
`define BIOZ_CFG_PARAMS_SVH

// Register byte offsets on the register bus
`define BZ_OFS_CHANNEL_CFG 8'h18
`define BZ_OFS_CONTROL 8'h40
`define BZ_OFS_STATUS 8'h44
`define BZ_OFS_MASK 8'h48

// Channel configuration field positions
`define BZ_RATE_BIT 23
`define BZ_ANALOG_HIGHPASS_SEL_MSB 22
`define BZ_ANALOG_HIGHPASS_SEL_LSB 20
`define BZ_EXTBIAS_BIT 19
`define BZ_LOWNOISE_BIT 18
`define BZ_GAIN_MSB 17
`define BZ_GAIN_LSB 16
`define BZ_DIGITAL_HIGHPASS_SEL_MSB 15
`define BZ_DIGITAL_HIGHPASS_SEL_LSB 14
`define BZ_DIGITAL_LOWPASS_SEL_MSB 13
`define BZ_DIGITAL_LOWPASS_SEL_LSB 12
`define BZ_MODULATION_FREQ_SEL_MSB 11
`define BZ_MODULATION_FREQ_SEL_LSB 8
`define BZ_COMPLIANCE_MONITOR_EN_BIT 7
`define BZ_DRIVE_CURRENT_SEL_MSB 6
`define BZ_DRIVE_CURRENT_SEL_LSB 4
`define BZ_MODULATION_PHASE_OFFSET_MSB 3
`define BZ_MODULATION_PHASE_OFFSET_LSB 0

// Control register fields
`define BZ_CTL_MCLK_MSB 1
`define BZ_CTL_MCLK_LSB 0
`define BZ_CTL_ACTIVE_BIT 2
`define BZ_CTL_RESYNC_BIT 3

// Status and mask bit positions
`define BZ_ST_COMPLY_BIT 0
`define BZ_ST_CFGWR_BIT 1
`define BZ_ST_RESYNC_BIT 2
`define BZ_ST_WIDTH 3

// Reset values
`define BZ_CFG_RESET 24'h20_1800
`define BZ_CTL_RESET 4'h0
`define BZ_MASK_RESET 3'h0

// Special codes
`define BZ_DIGITAL_LOWPASS_SEL_FALLBACK 2'h1
`define BZ_DIGITAL_LOWPASS_SEL_16HZ 2'h3
`define BZ_MODULATION_FREQ_SEL_SLOWEST 4'ha

`endif

//--- design/bioz_cfg_pkg.sv
// Types shared by the channel configuration block
package bioz_cfg_pkg;

	// Decoded configuration driven to the analog and digital channel
	typedef struct packed {
		logic rate_half;          // Lower output rate selected
		logic [2:0] analog_highpass_sel_cutoff;  // Analog high-pass cutoff code
		logic analog_highpass_sel_bypass;        // Analog high-pass bypassed
		logic ext_bias;           // External resistor bias in use
		logic low_noise;          // Amplifier low noise mode
		logic [1:0] gain;         // Gain code, 10 V/V times two to the code
		logic [1:0] digital_highpass_sel;         // Digital high-pass, 1x folded to 10
		logic [1:0] digital_lowpass_sel_eff;     // Effective digital low-pass code
		logic [3:0] mod_freq;     // Modulation code, slow codes folded to 1010
		logic mon_en;             // Compliance monitor enabled
		logic [6:0] current_ua;   // Drive current in microamps
		logic drive_on;           // Current generators running
		logic [3:0] phase_units;  // Phase offset in 11.25 degree units
	} bioz_fields_t;

	// One bus request as seen by the slave
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;

endpackage

//--- design/bioz_field_decode.sv
// Combinational decode of the stored channel configuration word
`timescale 1ns/1ps
`include "bioz_cfg_params.svh"

module bioz_field_decode
(
	input wire logic [23:0] raw_i,
	output bioz_cfg_pkg::bioz_fields_t fields_o,
	output logic [23:0] readback_o
);

	// Drive current for a magnitude code, zero when off
	function automatic logic [6:0] current_of(input logic [2:0] code);
		case (code)
			3'h1: current_of = 7'h08;
			3'h2: current_of = 7'h10;
			3'h3: current_of = 7'h20;
			3'h4: current_of = 7'h30;
			3'h5: current_of = 7'h40;
			3'h7: current_of = 7'h60;
			default: current_of = 7'h00;
		endcase
	endfunction

	logic [1:0] digital_lowpass_sel_raw; // Low-pass code as written
	logic [1:0] digital_lowpass_sel_eff; // Low-pass code in force
	logic [3:0] modulation_freq_sel;    // Modulation code as written
	logic [3:0] modulation_phase_offset;    // Phase code as written
	logic [2:0] drive_current_sel;    // Magnitude code as written

	// Field extraction and fallback decoding
	always_comb
	begin
		digital_lowpass_sel_raw = raw_i[`BZ_DIGITAL_LOWPASS_SEL_MSB:`BZ_DIGITAL_LOWPASS_SEL_LSB];
		modulation_freq_sel = raw_i[`BZ_MODULATION_FREQ_SEL_MSB:`BZ_MODULATION_FREQ_SEL_LSB];
		modulation_phase_offset = raw_i[`BZ_MODULATION_PHASE_OFFSET_MSB:`BZ_MODULATION_PHASE_OFFSET_LSB];
		drive_current_sel = raw_i[`BZ_DRIVE_CURRENT_SEL_MSB:`BZ_DRIVE_CURRENT_SEL_LSB];
		digital_lowpass_sel_eff = digital_lowpass_sel_raw;
		// 16 Hz only at the higher rate, else 4 Hz
		if (raw_i[`BZ_RATE_BIT] && digital_lowpass_sel_raw == `BZ_DIGITAL_LOWPASS_SEL_16HZ)
		begin
			digital_lowpass_sel_eff = `BZ_DIGITAL_LOWPASS_SEL_FALLBACK;
		end
		fields_o.rate_half = raw_i[`BZ_RATE_BIT];
		fields_o.analog_highpass_sel_cutoff = raw_i[`BZ_ANALOG_HIGHPASS_SEL_MSB:`BZ_ANALOG_HIGHPASS_SEL_LSB];
		fields_o.analog_highpass_sel_bypass = raw_i[`BZ_ANALOG_HIGHPASS_SEL_MSB] & raw_i[`BZ_ANALOG_HIGHPASS_SEL_MSB - 1];
		fields_o.ext_bias = raw_i[`BZ_EXTBIAS_BIT];
		fields_o.low_noise = raw_i[`BZ_LOWNOISE_BIT];
		fields_o.gain = raw_i[`BZ_GAIN_MSB:`BZ_GAIN_LSB];
		// Both upper codes give the same high-pass cutoff
		fields_o.digital_highpass_sel = raw_i[`BZ_DIGITAL_HIGHPASS_SEL_MSB] ? 2'h2 : raw_i[`BZ_DIGITAL_HIGHPASS_SEL_MSB:`BZ_DIGITAL_HIGHPASS_SEL_LSB];
		fields_o.digital_lowpass_sel_eff = digital_lowpass_sel_eff;
		// All codes from 1010 upward divide by 256
		fields_o.mod_freq = (modulation_freq_sel >= `BZ_MODULATION_FREQ_SEL_SLOWEST) ? `BZ_MODULATION_FREQ_SEL_SLOWEST : modulation_freq_sel;
		fields_o.mon_en = raw_i[`BZ_COMPLIANCE_MONITOR_EN_BIT];
		fields_o.current_ua = current_of(drive_current_sel);
		fields_o.drive_on = (current_of(drive_current_sel) != 7'h00);
		// Phase resolution coarsens at the two fastest modulation codes
		if (modulation_freq_sel == 4'h0)
		begin
			fields_o.phase_units = {modulation_phase_offset[3:2], 2'h0};
		end
		else if (modulation_freq_sel == 4'h1)
		begin
			fields_o.phase_units = {modulation_phase_offset[3:1], 1'b0};
		end
		else
		begin
			fields_o.phase_units = modulation_phase_offset;
		end
		// Read back shows the low-pass code in force
		readback_o = raw_i;
		readback_o[`BZ_DIGITAL_LOWPASS_SEL_MSB:`BZ_DIGITAL_LOWPASS_SEL_LSB] = digital_lowpass_sel_eff;
	end

endmodule

//--- design/bioz_channel_config.sv
// Wishbone register block holding and driving the bioimpedance channel configuration
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`include "bioz_cfg_params.svh"

// Summary of operation
// - Analog high-pass code, reset 010, 11x bypasses
// - Bit 19 picks internal or external bias
// - Bit 18 picks low power or low noise
// - Two-bit gain code, 10 to 80 V/V
// - Digital high-pass: bypass, 0.05 Hz, 0.5 Hz
// - Digital low-pass: decimate only, 4, 8, 16
// - 16 Hz low-pass only at higher rate
// - Unsupported low-pass runs 4 Hz, reads effective
// - Modulation code divides master clock, slow codes fold
// - Monitor enable gated by active channel, generators
// - Magnitude code sets current, zero floats drives
// - Phase offset resolution follows modulation code
// - Bit 23 halves the output rate
// - Resync command restores timing after changes
// - Whole register readable and writable by software
module bioz_channel_config
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	input wire logic compliance_fault_i,
	output bioz_cfg_pkg::bioz_fields_t fields_o,
	output logic [1:0] master_clock_sel_o,
	output logic channel_active_o,
	output logic resync_command_o,
	output logic drive_out_pos_oe_o,
	output logic drive_out_neg_oe_o
);

	// Merge a write word into a stored word under byte enables
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
			begin
				res[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		merge_bytes = res;
	endfunction

	// Bus request bundle
	bioz_cfg_pkg::wb_req_t req;

	// Stored registers
	logic [23:0] channel_config_reg; // Configuration as written
	logic [3:0] control;             // Master clock, active, bit 3 held zero
	logic [`BZ_ST_WIDTH-1:0] status; // Sticky event flags
	logic [`BZ_ST_WIDTH-1:0] mask;   // Interrupt enables

	// Access qualifiers
	logic access;      // New request this cycle
	logic wr_access;   // Write this cycle
	logic hit_cfg;     // Address hits channel config
	logic hit_ctl;     // Address hits control
	logic hit_st;      // Address hits status
	logic hit_mask;    // Address hits mask

	// Decoder results
	bioz_cfg_pkg::bioz_fields_t next_fields; // Decoded fields of stored word
	logic [23:0] cfg_readback;               // Config as read by software

	// Synchroniser for the external compliance comparator
	logic fault_meta;   // First stage, read only by second stage
	logic fault_sync;   // Second stage
	logic fault_event;  // Qualified compliance event

	// Events for the status register
	logic [`BZ_ST_WIDTH-1:0] events;
	logic [31:0] next_ctl_word; // Control after byte merge
	logic [31:0] next_cfg_word; // Config after byte merge
	logic [31:0] next_mask_word; // Mask after byte merge

	// Request bundling and address decode
	always_comb
	begin
		req.cyc = wb_cyc_i;
		req.stb = wb_stb_i;
		req.we = wb_we_i;
		req.adr = wb_adr_i;
		req.sel = wb_sel_i;
		req.dat = wb_dat_i;
		// One access per request, none while ack is out
		access = req.cyc & req.stb & ~wb_ack_o;
		wr_access = access & req.we;
		hit_cfg = (req.adr == `BZ_OFS_CHANNEL_CFG);
		hit_ctl = (req.adr == `BZ_OFS_CONTROL);
		hit_st = (req.adr == `BZ_OFS_STATUS);
		hit_mask = (req.adr == `BZ_OFS_MASK);
		next_ctl_word = merge_bytes({28'h000_0000, control}, req.dat, req.sel);
		next_cfg_word = merge_bytes({8'h00, channel_config_reg}, req.dat, req.sel);
		next_mask_word = merge_bytes({29'h0000_0000, mask}, req.dat, req.sel);
	end

	// Field decoder of the stored configuration
	bioz_field_decode u_decode
	(
		.raw_i(channel_config_reg),
		.fields_o(next_fields),
		.readback_o(cfg_readback)
	);

	// Bus acknowledge, one cycle after the request is seen
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
		end
		else
		begin
			wb_ack_o <= access;
		end
	end

	// Read data, captured with the access
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_dat_o <= 32'h0000_0000;
		end
		else if (access && !req.we)
		begin
			if (hit_cfg)
			begin
				wb_dat_o <= {8'h00, cfg_readback};
			end
			else if (hit_ctl)
			begin
				// Resync bit is a strobe and reads zero
				wb_dat_o <= {28'h000_0000, 1'b0, control[2:0]};
			end
			else if (hit_st)
			begin
				wb_dat_o <= {29'h0000_0000, status};
			end
			else if (hit_mask)
			begin
				wb_dat_o <= {29'h0000_0000, mask};
			end
			else
			begin
				// Unmapped reads return zero
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end

	// Channel configuration register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			channel_config_reg <= `BZ_CFG_RESET;
		end
		else if (wr_access && hit_cfg)
		begin
			// Raw value is kept even when a code is unsupported
			channel_config_reg <= next_cfg_word[23:0];
		end
	end

	// Control register: master clock choice and channel active
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			control <= `BZ_CTL_RESET;
		end
		else if (wr_access && hit_ctl)
		begin
			control <= {1'b0, next_ctl_word[2:0]};
		end
	end

	// Resync strobe, one cycle after a write of one
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			resync_command_o <= 1'b0;
		end
		else
		begin
			resync_command_o <= wr_access & hit_ctl & req.sel[0] & req.dat[`BZ_CTL_RESYNC_BIT];
		end
	end

	// Mask register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mask <= `BZ_MASK_RESET;
		end
		else if (wr_access && hit_mask)
		begin
			mask <= next_mask_word[`BZ_ST_WIDTH-1:0];
		end
	end

	// Two-stage synchroniser for the comparator pin
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fault_meta <= 1'b0;
			fault_sync <= 1'b0;
		end
		else
		begin
			fault_meta <= compliance_fault_i;
			fault_sync <= fault_meta;
		end
	end

	// Event sources for the sticky status bits
	always_comb
	begin
		// Monitor only counts with channel active and drive running
		fault_event = fault_sync & fields_o.mon_en & channel_active_o & fields_o.drive_on;
		events = '0;
		events[`BZ_ST_COMPLY_BIT] = fault_event;
		// A config write may disturb the record until resynced
		events[`BZ_ST_CFGWR_BIT] = wr_access & hit_cfg;
		events[`BZ_ST_RESYNC_BIT] = resync_command_o;
	end

	// Sticky status, write one to clear, a new event wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			status <= '0;
		end
		else if (wr_access && hit_st && req.sel[0])
		begin
			status <= (status & ~req.dat[`BZ_ST_WIDTH-1:0]) | events;
		end
		else
		begin
			status <= status | events;
		end
	end

	// Interrupt level from unmasked status
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_o <= 1'b0;
		end
		else
		begin
			irq_o <= |(status & mask);
		end
	end

	// Decoded fields registered onto the outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fields_o <= '0;
			fields_o.analog_highpass_sel_cutoff <= 3'h2;
			fields_o.digital_lowpass_sel_eff <= `BZ_DIGITAL_LOWPASS_SEL_FALLBACK;
			fields_o.mod_freq <= 4'h8;
		end
		else
		begin
			fields_o <= next_fields;
		end
	end

	// Control outputs and drive enables
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			master_clock_sel_o <= 2'h0;
			channel_active_o <= 1'b0;
			drive_out_pos_oe_o <= 1'b0;
			drive_out_neg_oe_o <= 1'b0;
		end
		else
		begin
			master_clock_sel_o <= control[`BZ_CTL_MCLK_MSB:`BZ_CTL_MCLK_LSB];
			channel_active_o <= control[`BZ_CTL_ACTIVE_BIT];
			// Magnitude off leaves both drives floating
			drive_out_pos_oe_o <= next_fields.drive_on & control[`BZ_CTL_ACTIVE_BIT];
			drive_out_neg_oe_o <= next_fields.drive_on & control[`BZ_CTL_ACTIVE_BIT];
		end
	end

endmodule

//--- sim/bioz_channel_config_checker.sv
// Port assertions for the channel configuration block
`timescale 1ns/1ps
module bioz_channel_config_checker
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq_o,
	input wire bioz_cfg_pkg::bioz_fields_t fields_o,
	input wire logic channel_active_o,
	input wire logic resync_command_o,
	input wire logic drive_out_pos_oe_o,
	input wire logic drive_out_neg_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic take; // Request accepted at this edge
	logic cfg_wr; // Full-word write of the config register
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign cfg_wr = take && wb_we_i && wb_adr_i == 8'h18 && wb_sel_i == 4'hf;
	chk_ack_pulse: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse");
	chk_field_copy: assert property (cfg_wr |-> ##2 fields_o.gain == $past(wb_dat_i[17:16], 2)
		&& fields_o.ext_bias == $past(wb_dat_i[19], 2) && fields_o.low_noise == $past(wb_dat_i[18], 2))
		else $error("gain or bias fields wrong");
	chk_analog_highpass_sel_bypass: assert property (cfg_wr |-> ##2 fields_o.analog_highpass_sel_cutoff == $past(wb_dat_i[22:20], 2)
		&& fields_o.analog_highpass_sel_bypass == (&$past(wb_dat_i[22:21], 2))) else $error("analog high-pass wrong");
	chk_digital_lowpass_sel_fallback: assert property (cfg_wr && wb_dat_i[23] && wb_dat_i[13:12] == 2'h3
		|-> ##2 fields_o.digital_lowpass_sel_eff == 2'h1) else $error("low-pass fallback missing");
	chk_phase_coarse: assert property (cfg_wr && wb_dat_i[11:8] == 4'h0
		|-> ##2 fields_o.phase_units == {$past(wb_dat_i[3:2], 2), 2'h0}) else $error("phase units wrong");
	chk_mod_fold: assert property (cfg_wr && wb_dat_i[11] && wb_dat_i[10:9] != 2'h0
		|-> ##2 fields_o.mod_freq == 4'ha) else $error("slow modulation code not folded");
	chk_drive_gate: assert property (drive_out_pos_oe_o == (fields_o.drive_on && channel_active_o)
		&& drive_out_neg_oe_o == drive_out_pos_oe_o) else $error("drive enables wrong");
	chk_resync_pulse: assert property (take && wb_we_i && wb_adr_i == 8'h40 && wb_sel_i[0] && wb_dat_i[3]
		|=> resync_command_o ##1 !resync_command_o) else $error("resync pulse wrong");
	chk_reset_state: assert property ($fell(rst_i) |-> fields_o.analog_highpass_sel_cutoff == 3'h2
		&& fields_o.digital_lowpass_sel_eff == 2'h1 && fields_o.mod_freq == 4'h8 && !irq_o && !wb_ack_o)
		else $error("reset state wrong");
	chk_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i == 8'h7c |=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule

bind bioz_channel_config bioz_channel_config_checker bioz_channel_config_checker_inst (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
	.fields_o(fields_o), .channel_active_o(channel_active_o), .resync_command_o(resync_command_o),
	.drive_out_pos_oe_o(drive_out_pos_oe_o), .drive_out_neg_oe_o(drive_out_neg_oe_o));

//--- sim/bioimpedance_channel_config_tb_top.sv
// Self-checking bench for the channel configuration block
`timescale 1ns/1ps
module bioimpedance_channel_config_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic fault = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] rd; // Last read data
	logic [31:0] dat_o;
	logic ack, irq, act, resync, pos_oe, neg_oe;
	logic [1:0] mclk;
	bioz_cfg_pkg::bioz_fields_t fields;
	int n_errors = 0;
	int comparisons = 0;

	bioz_channel_config bioz_channel_config_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.irq_o(irq), .compliance_fault_i(fault), .fields_o(fields), .master_clock_sel_o(mclk),
		.channel_active_o(act), .resync_command_o(resync), .drive_out_pos_oe_o(pos_oe),
		.drive_out_neg_oe_o(neg_oe));

	// Free-running 100 MHz clock
	initial forever #5 clk_i = ~clk_i;

	// One classic Wishbone cycle, held until ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// Word comparison
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: %s", $time, m);
			n_errors++;
		end
	endtask

	// Expected decode of a stored word
	function automatic bioz_cfg_pkg::bioz_fields_t model(input logic [23:0] w);
		bioz_cfg_pkg::bioz_fields_t f;
		logic [6:0] ua [8] = '{7'h00, 7'h08, 7'h10, 7'h20, 7'h30, 7'h40, 7'h00, 7'h60};
		f.rate_half = w[23];
		f.analog_highpass_sel_cutoff = w[22:20];
		f.analog_highpass_sel_bypass = w[22] & w[21];
		f.ext_bias = w[19];
		f.low_noise = w[18];
		f.gain = w[17:16];
		f.digital_highpass_sel = w[15] ? 2'h2 : w[15:14];
		f.digital_lowpass_sel_eff = (w[23] && w[13:12] == 2'h3) ? 2'h1 : w[13:12];
		f.mod_freq = (w[11] && w[10:9] != 2'h0) ? 4'ha : w[11:8];
		f.mon_en = w[7];
		f.current_ua = ua[w[6:4]];
		f.drive_on = f.current_ua != 7'h00;
		f.phase_units = w[11:9] != 3'h0 ? w[3:0] : (w[8] ? {w[3:1], 1'b0} : {w[3:2], 2'h0});
		return f;
	endfunction

	// Write the config word, then check decode and readback
	task automatic cfg(input logic [23:0] w);
		bioz_cfg_pkg::bioz_fields_t e;
		e = model(w);
		bus(1'b1, 8'h18, {8'h00, w}, 4'hf);
		@(negedge clk_i);
		check({2'h0, fields}, {2'h0, e}, "decoded fields");
		bus(1'b0, 8'h18, 32'h0000_0000, 4'hf);
		check(rd, {8'h00, w[23:14], e.digital_lowpass_sel_eff, w[11:0]}, "config readback");
	endtask

	// Read one register and compare
	task automatic rcheck(input logic [7:0] a, input logic [31:0] exp, input string m);
		bus(1'b0, a, 32'h0000_0000, 4'hf);
		check(rd, exp, m);
	endtask

	task automatic test_reset;
		rcheck(8'h18, 32'h0020_1800, "config reset");
		check({2'h0, fields}, {2'h0, model(24'h20_1800)}, "fields reset");
		$display("test_reset done");
	endtask

	// Every code of each field but rate, low-pass and phase, which stay fixed; all eight magnitude codes
	task automatic test_codes;
		logic [3:0] k;
		logic [2:0] mag;
		for (int i = 0; i < 16; i++)
		begin
			k = 4'(i);
			mag = i < 7 ? 3'(7 - i) : {2'h0, k[0]};
			cfg({1'b0, k[2:0], k[0], k[1], k[1:0], k[1:0], 2'h2, k, k[0], mag, 4'hf});
		end
		$display("test_codes done");
	endtask

	task automatic test_lowpass;
		cfg(24'h80_3000);
		cfg(24'h00_3000);
		cfg(24'h80_0000);
		$display("test_lowpass done");
	endtask

	task automatic test_bus;
		bus(1'b1, 8'h7c, 32'hffff_ffff, 4'hf);
		rcheck(8'h7c, 32'h0000_0000, "unmapped read");
		bus(1'b1, 8'h18, 32'hffff_ffff, 4'h1);
		rcheck(8'h18, 32'h0080_00ff, "byte write");
		$display("test_bus done");
	endtask

	task automatic test_drive;
		cfg(24'h00_0810);
		check({mclk, act, pos_oe, neg_oe}, 32'h0, "drive off while idle");
		bus(1'b1, 8'h40, 32'h0000_0007, 4'hf);
		@(negedge clk_i);
		check({mclk, act, pos_oe, neg_oe}, 32'h1f, "drive on");
		cfg(24'h00_0800);
		check({mclk, act, pos_oe, neg_oe}, 32'h1c, "drive floating");
		$display("test_drive done");
	endtask

	// Status, mask and interrupt paths
	task automatic test_irq;
		bus(1'b1, 8'h48, 32'h0000_0003, 4'hf);
		bus(1'b1, 8'h44, 32'h0000_0007, 4'hf);
		@(negedge clk_i);
		check(irq, 32'h0, "irq cleared");
		cfg(24'h00_0890);
		check(irq, 32'h1, "irq on config write");
		bus(1'b1, 8'h44, 32'h0000_0002, 4'hf);
		@(posedge clk_i);
		fault <= 1'b1;
		repeat (5) @(posedge clk_i);
		rcheck(8'h44, 32'h0000_0001, "monitor event");
		check(irq, 32'h1, "irq on monitor event");
		bus(1'b1, 8'h48, 32'h0000_0000, 4'hf);
		@(negedge clk_i);
		check(irq, 32'h0, "irq masked");
		cfg(24'h00_0810);
		bus(1'b1, 8'h44, 32'h0000_0007, 4'hf);
		repeat (5) @(posedge clk_i);
		rcheck(8'h44, 32'h0000_0000, "monitor disabled");
		fault <= 1'b0;
		$display("test_irq done");
	endtask

	task automatic test_resync;
		bus(1'b1, 8'h40, 32'h0000_000c, 4'h1);
		rcheck(8'h40, 32'h0000_0004, "resync reads zero");
		rcheck(8'h44, 32'h0000_0004, "resync status");
		$display("test_resync done");
	endtask

	// Counts and verdict, then stop
	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		print_verdict;
	end

	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		test_reset;
		test_codes;
		test_lowpass;
		test_bus;
		test_drive;
		test_irq;
		test_resync;
		print_verdict;
	end
endmodule
